// *** verilog/isp_pkg.sv ***
/*
 Constants, register map and carrier types of the in-system programming
 sequencer. Assumes an APB host with 32-bit data and one 8-bit register per
 aligned word, byte address four times the register index.
*/
// Notes on behaviour
// - Soft reset bit resets whole device, self-clears
// - Soft reset bit reads hardware reboot status
// - Execution source bit read-only, one means loader
// - Loader select makes fetches come from loader
// - Programming enable enters programming mode
// - Idle request in programming mode starts operation
// - Clearing programming enable restores ordinary idle
// - Value 0x83, timer, idle: restart from application
// - Address pair gives byte address; erase ignores it
// - All flash data passes the data buffer
// - Bank bit picks application bank one or zero
// - Target bit picks application or loader flash
// - Codes 0010 erase, 0001 program, 0000 read
// - Bank extension drives a port-1 pin as A16
// - Pin select field picks port-1 pin, default 7
package isp_pkg;
  // Register indices; byte address is index times four
  localparam logic [7:0] IDX_CHIP_PROGRAM_CONTROL = 8'h9f;
  localparam logic [7:0] IDX_ROM_BANK_CONTROL = 8'hab;
  localparam logic [7:0] IDX_PROGRAM_ADDRESS_LOW = 8'hac;
  localparam logic [7:0] IDX_PROGRAM_ADDRESS_HIGH = 8'had;
  localparam logic [7:0] IDX_PROGRAM_DATA_BUFFER = 8'hae;
  localparam logic [7:0] IDX_PROGRAM_OPERATION_SELECT = 8'haf;
  localparam logic [7:0] IDX_IDLE_REQUEST = 8'hf8;
  // Chip program control fields
  localparam int CPC_SOFT_RESET_BIT = 7;
  localparam int CPC_EXEC_SOURCE_BIT = 5;
  localparam int CPC_LOADER_SELECT_BIT = 1;
  localparam int CPC_PROG_ENABLE_BIT = 0;
  localparam logic [7:0] CPC_SW_RESTART_VALUE = 8'h83;
  // Rom bank control fields
  localparam int RBC_EXT_ENABLE_BIT = 3;
  localparam int RBC_PIN_SEL_LSB = 0;
  localparam logic [7:0] RBC_RESET = 8'h07;
  // Operation select fields
  localparam int OPS_BANK_BIT = 7;
  localparam int OPS_TARGET_BIT = 6;
  localparam int OPS_OE_N_BIT = 5;
  localparam int OPS_CE_N_BIT = 4;
  localparam logic [7:0] OPS_RESET = 8'h00;
  // Idle request register field
  localparam int IDLE_REQUEST_BIT = 1;
  localparam logic [7:0] REG_ZERO = 8'h00;

  typedef enum logic [3:0] {
    ISP_OP_READ = 4'h0,
    ISP_OP_PROGRAM = 4'h1,
    ISP_OP_ERASE = 4'h2
  } isp_op_e;

  typedef enum logic [1:0] {
    ISP_ST_RUN = 2'b00,
    ISP_ST_BUSY = 2'b01,
    ISP_ST_DONE = 2'b11
  } isp_state_e;

  typedef struct packed {
    logic [3:0] op;
    logic to_loader;
    logic bank1;
    logic [15:0] addr;
    logic [7:0] wdata;
  } isp_flash_req_s;
endpackage : isp_pkg

// *** verilog/isp_flash_sequencer.sv ***
/*
 In-system programming sequencer: APB register file, flash operation
 sequencer, soft reset and restart, code fetch source and A16 banking pin.
 Assumes flash arrays and CPU on pclk; the reboot strap is asynchronous.
*/
module isp_flash_sequencer
  import isp_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Flash arrays
  output isp_flash_req_s flash_req,
  output logic flash_req_valid,
  input wire logic flash_done,
  input wire logic [7:0] flash_rdata,
  // CPU side
  output logic cpu_stall,
  output logic cpu_idle,
  input wire logic cpu_wake,
  input wire logic restart_timer_expired,
  output logic soft_reset,
  output logic fetch_from_loader,
  input wire logic hw_reboot_strap,
  input wire logic code_addr16,
  // Port-1 extra address line
  output logic [7:0] p1_a16_o,
  output logic [7:0] p1_a16_oe
);

  if (ADDR_W < 10) begin : g_addr_w_check
    $error("ADDR_W must hold index times four");
  end

  isp_state_e state_q;
  logic ack_q;
  logic err_q;
  logic [7:0] rdata_q;
  logic soft_rst_q;
  logic restart_pend_q;
  logic loader_fetch_select_q;
  logic enp_q;
  logic idle_req_q;
  logic [7:0] rom_bank_control_q;
  logic [7:0] addr_lo_q;
  logic [7:0] addr_hi_q;
  logic [7:0] data_q;
  logic [7:0] opsel_q;
  logic reboot_s1_q;
  logic reboot_s2_q;
  logic [7:0] idx;
  logic mapped;
  logic wr_en;
  logic [7:0] wbyte;
  logic [7:0] rd_val;
  logic launch;
  logic op_legal;

  assign idx = paddr[9:2];
  assign wbyte = pwdata[7:0];

  // Address decode and read mux
  always_comb begin
    mapped = 1'b1;
    rd_val = REG_ZERO;
    if (idx == IDX_CHIP_PROGRAM_CONTROL) begin
      rd_val[CPC_SOFT_RESET_BIT] = reboot_s2_q;
      rd_val[CPC_EXEC_SOURCE_BIT] = loader_fetch_select_q;
      rd_val[CPC_LOADER_SELECT_BIT] = loader_fetch_select_q;
      rd_val[CPC_PROG_ENABLE_BIT] = enp_q;
    end else if (idx == IDX_ROM_BANK_CONTROL) begin
      rd_val = rom_bank_control_q;
    end else if (idx == IDX_PROGRAM_ADDRESS_LOW) begin
      rd_val = addr_lo_q;
    end else if (idx == IDX_PROGRAM_ADDRESS_HIGH) begin
      rd_val = addr_hi_q;
    end else if (idx == IDX_PROGRAM_DATA_BUFFER) begin
      rd_val = data_q;
    end else if (idx == IDX_PROGRAM_OPERATION_SELECT) begin
      rd_val = opsel_q;
    end else if (idx == IDX_IDLE_REQUEST) begin
      rd_val[IDLE_REQUEST_BIT] = idle_req_q;
    end else begin
      mapped = 1'b0;
    end
    if (paddr[1:0] != 2'b00) begin
      mapped = 1'b0;
    end
  end

  // APB: one wait cycle, answer registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_q <= 1'b0;
      err_q <= 1'b0;
      rdata_q <= REG_ZERO;
    end else if (psel && penable && !ack_q) begin
      ack_q <= 1'b1;
      err_q <= !mapped;
      rdata_q <= mapped ? rd_val : REG_ZERO;
    end else begin
      ack_q <= 1'b0;
      err_q <= 1'b0;
    end
  end

  assign pready = ack_q;
  assign pslverr = ack_q && err_q;
  assign prdata = {24'h000000, rdata_q};
  assign wr_en = psel && penable && pwrite && ack_q && !err_q;

  // Reboot strap synchroniser
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reboot_s1_q <= 1'b0;
      reboot_s2_q <= 1'b0;
    end else begin
      reboot_s1_q <= hw_reboot_strap;
      reboot_s2_q <= reboot_s1_q;
    end
  end

  // Soft reset and timed restart
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      soft_rst_q <= 1'b0;
      restart_pend_q <= 1'b0;
    end else if (soft_rst_q) begin
      soft_rst_q <= 1'b0;
      restart_pend_q <= 1'b0;
    end else if (wr_en && idx == IDX_CHIP_PROGRAM_CONTROL
                 && wbyte[CPC_SOFT_RESET_BIT]) begin
      if (wbyte == CPC_SW_RESTART_VALUE) begin
        restart_pend_q <= 1'b1;
      end else begin
        soft_rst_q <= 1'b1;
      end
    end else if (restart_pend_q && idle_req_q && restart_timer_expired) begin
      soft_rst_q <= 1'b1;
    end
  end

  assign soft_reset = soft_rst_q;

  // Chip program control
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      loader_fetch_select_q <= 1'b0;
      enp_q <= 1'b0;
    end else if (soft_rst_q) begin
      loader_fetch_select_q <= 1'b0;
      enp_q <= 1'b0;
    end else if (wr_en && idx == IDX_CHIP_PROGRAM_CONTROL) begin
      loader_fetch_select_q <= wbyte[CPC_LOADER_SELECT_BIT];
      enp_q <= wbyte[CPC_PROG_ENABLE_BIT];
    end
  end

  assign fetch_from_loader = loader_fetch_select_q;

  // Operand registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rom_bank_control_q <= RBC_RESET;
      addr_lo_q <= REG_ZERO;
      addr_hi_q <= REG_ZERO;
      opsel_q <= OPS_RESET;
    end else if (soft_rst_q) begin
      rom_bank_control_q <= RBC_RESET;
      addr_lo_q <= REG_ZERO;
      addr_hi_q <= REG_ZERO;
      opsel_q <= OPS_RESET;
    end else if (wr_en) begin
      if (idx == IDX_ROM_BANK_CONTROL) begin
        rom_bank_control_q <= {4'h0, wbyte[3:0]};
      end else if (idx == IDX_PROGRAM_ADDRESS_LOW) begin
        addr_lo_q <= wbyte;
      end else if (idx == IDX_PROGRAM_ADDRESS_HIGH) begin
        addr_hi_q <= wbyte;
      end else if (idx == IDX_PROGRAM_OPERATION_SELECT) begin
        opsel_q <= wbyte;
      end
    end
  end

  // Data buffer: software load or read result
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_q <= REG_ZERO;
    end else if (soft_rst_q) begin
      data_q <= REG_ZERO;
    end else if (state_q == ISP_ST_BUSY && flash_done
                 && flash_req.op == ISP_OP_READ) begin
      data_q <= flash_rdata;
    end else if (wr_en && idx == IDX_PROGRAM_DATA_BUFFER) begin
      data_q <= wbyte;
    end
  end

  // Idle request: operation, true idle or restart wait
  assign op_legal = !opsel_q[OPS_CE_N_BIT]
    && (opsel_q[3:0] == ISP_OP_READ || opsel_q[3:0] == ISP_OP_PROGRAM
        || opsel_q[3:0] == ISP_OP_ERASE);
  assign launch = wr_en && idx == IDX_IDLE_REQUEST
    && wbyte[IDLE_REQUEST_BIT] && enp_q && !restart_pend_q
    && state_q == ISP_ST_RUN;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idle_req_q <= 1'b0;
    end else if (soft_rst_q) begin
      idle_req_q <= 1'b0;
    end else if (state_q == ISP_ST_DONE) begin
      idle_req_q <= 1'b0;
    end else if (wr_en && idx == IDX_IDLE_REQUEST) begin
      idle_req_q <= wbyte[IDLE_REQUEST_BIT];
    end else if (cpu_wake && !enp_q && !restart_pend_q) begin
      idle_req_q <= 1'b0;
    end
  end

  assign cpu_idle = idle_req_q && (!enp_q || restart_pend_q);

  // Flash operation sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ISP_ST_RUN;
      flash_req <= '0;
    end else if (soft_rst_q) begin
      state_q <= ISP_ST_RUN;
      flash_req <= '0;
    end else begin
      case (state_q)
        ISP_ST_RUN: begin
          if (launch) begin
            state_q <= op_legal ? ISP_ST_BUSY : ISP_ST_DONE;
            flash_req.op <= opsel_q[3:0];
            flash_req.to_loader <= opsel_q[OPS_TARGET_BIT];
            flash_req.bank1 <= opsel_q[OPS_BANK_BIT];
            flash_req.addr <= (opsel_q[3:0] == ISP_OP_ERASE) ? 16'h0000
              : {addr_hi_q, addr_lo_q};
            flash_req.wdata <= data_q;
          end
        end
        ISP_ST_BUSY: begin
          if (flash_done) begin
            state_q <= ISP_ST_DONE;
          end
        end
        ISP_ST_DONE: begin
          state_q <= ISP_ST_RUN;
        end
        default: begin
          state_q <= ISP_ST_RUN;
        end
      endcase
    end
  end

  assign flash_req_valid = state_q == ISP_ST_BUSY;
  assign cpu_stall = state_q != ISP_ST_RUN;

  // Bank extension pin
  always_comb begin
    p1_a16_oe = 8'h00;
    if (rom_bank_control_q[RBC_EXT_ENABLE_BIT]) begin
      p1_a16_oe = 8'h01 << rom_bank_control_q[RBC_PIN_SEL_LSB +: 3];
    end
    p1_a16_o = p1_a16_oe & {8{code_addr16}};
  end

  // Checks
  logic rd_cpc;
  // Answer cycle of a chip control read; ack lasts one cycle only
  assign rd_cpc = ack_q && psel && penable && !pwrite && idx == IDX_CHIP_PROGRAM_CONTROL;

  sequence s_launch;
    launch && op_legal;
  endsequence

  sequence s_busy_done;
    (flash_req_valid && cpu_stall) ##1 1'b1;
  endsequence

  property p_soft_reset_clears;
    @(posedge pclk) disable iff (!presetn)
    soft_rst_q |=> !soft_rst_q && !enp_q && !loader_fetch_select_q && state_q == ISP_ST_RUN;
  endproperty
  a_soft_reset_clears: assert property (p_soft_reset_clears)
    else $error("soft reset left state behind");

  property p_reboot_read;
    @(posedge pclk) disable iff (!presetn)
    rd_cpc |-> prdata[7] == $past(reboot_s2_q);
  endproperty
  a_reboot_read: assert property (p_reboot_read)
    else $error("reboot flag read wrong");

  property p_exec_source;
    @(posedge pclk) disable iff (!presetn)
    rd_cpc |-> prdata[5] == fetch_from_loader;
  endproperty
  a_exec_source: assert property (p_exec_source)
    else $error("exec source bit wrong");

  property p_launch;
    @(posedge pclk) disable iff (!presetn)
    s_launch |=> s_busy_done;
  endproperty
  a_launch: assert property (p_launch)
    else $error("idle request did not start operation");

  property p_true_idle;
    @(posedge pclk) disable iff (!presetn)
    (wr_en && idx == IDX_IDLE_REQUEST && wbyte[IDLE_REQUEST_BIT] && !enp_q)
      |=> cpu_idle && !flash_req_valid;
  endproperty
  a_true_idle: assert property (p_true_idle)
    else $error("idle without enable not ordinary");

  property p_read_data;
    @(posedge pclk) disable iff (!presetn)
    (flash_req_valid && flash_done && flash_req.op == ISP_OP_READ)
      |=> data_q == $past(flash_rdata) ##1 !cpu_stall;
  endproperty
  a_read_data: assert property (p_read_data)
    else $error("read byte not returned");

  property p_erase_addr;
    @(posedge pclk) disable iff (!presetn)
    flash_req_valid && flash_req.op == ISP_OP_ERASE |-> flash_req.addr == 16'h0000;
  endproperty
  a_erase_addr: assert property (p_erase_addr)
    else $error("erase carried an address");

  property p_a16_pin;
    @(posedge pclk) disable iff (!presetn)
    rom_bank_control_q[RBC_EXT_ENABLE_BIT] |-> p1_a16_oe == (8'h01 << rom_bank_control_q[2:0]);
  endproperty
  a_a16_pin: assert property (p_a16_pin)
    else $error("wrong A16 pin");

  property p_restart;
    @(posedge pclk) disable iff (!presetn)
    (restart_pend_q && idle_req_q && restart_timer_expired && !soft_rst_q)
      |=> soft_rst_q ##1 !fetch_from_loader;
  endproperty
  a_restart: assert property (p_restart)
    else $error("timed restart missing");

endmodule : isp_flash_sequencer

// *** verification/isp_flash_model.sv ***
/*
 Behavioural flash arrays: loader array and two application banks.
 Assumes one request at a time from the sequencer, all on pclk.
*/
module isp_flash_model
  import isp_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Request side
  input wire isp_flash_req_s flash_req,
  input wire logic flash_req_valid,
  output logic flash_done,
  output logic [7:0] flash_rdata
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] mem [logic [17:0]];
  logic [17:0] kq [$];
  logic [17:0] key;
  logic [3:0] cnt_q;
  logic [3:0] lat_q;
  assign key = {flash_req.to_loader, flash_req.bank1 & ~flash_req.to_loader, flash_req.addr};
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 4'h0;
      lat_q <= 4'h1;
      flash_done <= 1'b0;
      flash_rdata <= 8'h5a;
    end else if (flash_req_valid && !flash_done) begin
      if (cnt_q == lat_q) begin
        flash_done <= 1'b1;
        cnt_q <= 4'h0;
        // Latency grows by three after each answer and wraps modulo 16
        lat_q <= lat_q + 4'h3;
        if (flash_req.op == ISP_OP_ERASE) begin
          foreach (mem[k]) if (k[17:16] == key[17:16]) kq.push_back(k);
          foreach (kq[i]) mem.delete(kq[i]);
          kq.delete();
        end else if (flash_req.op == ISP_OP_PROGRAM) begin
          mem[key] = flash_req.wdata;
        end else begin
          flash_rdata <= mem.exists(key) ? mem[key] : 8'hff;
        end
      end else begin
        cnt_q <= cnt_q + 4'h1;
      end
    end else begin
      flash_done <= 1'b0;
      // Data lines held while a request waits, toggled each cycle when none waits or done is high
      flash_rdata <= ~flash_rdata;
    end
  end
endmodule : isp_flash_model

// *** verification/isp_flash_sequencer_test.sv ***
/*
 Self-checking bench of the programming sequencer with flash model.
 Assumes the register map and hand-over timing of the sequencer package.
*/
module isp_flash_sequencer_test
  import isp_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, rerr;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rdat;
  logic pready, pslverr, flash_req_valid, flash_done, cpu_stall, cpu_idle, soft_reset;
  logic fetch_from_loader, cpu_wake = 0, restart_timer_expired = 0;
  logic hw_reboot_strap = 0, code_addr16 = 0;
  logic [7:0] flash_rdata, p1_a16_o, p1_a16_oe;
  isp_flash_req_s flash_req;
  logic [7:0] ref_mem [logic [17:0]];
  int mismatches = 0, cmp_count = 0, sr_cnt = 0, n0, seed = 32'h98eb;
  logic [31:0] r;

  isp_flash_sequencer i_isp_flash_sequencer (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .flash_req(flash_req),
    .flash_req_valid(flash_req_valid), .flash_done(flash_done), .flash_rdata(flash_rdata),
    .cpu_stall(cpu_stall), .cpu_idle(cpu_idle), .cpu_wake(cpu_wake),
    .restart_timer_expired(restart_timer_expired), .soft_reset(soft_reset),
    .fetch_from_loader(fetch_from_loader), .hw_reboot_strap(hw_reboot_strap),
    .code_addr16(code_addr16), .p1_a16_o(p1_a16_o), .p1_a16_oe(p1_a16_oe));
  isp_flash_model i_isp_flash_model (.pclk(pclk), .presetn(presetn), .flash_req(flash_req),
    .flash_req_valid(flash_req_valid), .flash_done(flash_done), .flash_rdata(flash_rdata));

  initial forever #50 pclk = ~pclk;
  always @(posedge pclk) if (soft_reset === 1'b1) sr_cnt++;

  task automatic give_verdict();
    if (mismatches == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'($random(seed)), wd};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) mismatches++;
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  function automatic logic [7:0] exp_rd(input logic [17:0] k);
    return ref_mem.exists(k) ? ref_mem[k] : 8'hff;
  endfunction : exp_rd

  task automatic flash_op(input logic [3:0] op, input logic ldr, input logic bk,
                          input logic [15:0] a, input logic [7:0] d, input logic ce_n);
    logic [17:0] kq [$];
    logic [17:0] k;
    logic bad;
    int n;
    k = {ldr, bk & ~ldr, a};
    bad = ce_n || op > 4'h2;
    apb(1, IDX_PROGRAM_ADDRESS_LOW, a[7:0]);
    apb(1, IDX_PROGRAM_ADDRESS_HIGH, a[15:8]);
    apb(1, IDX_PROGRAM_DATA_BUFFER, d);
    apb(1, IDX_PROGRAM_OPERATION_SELECT, {bk, ldr, op != ISP_OP_READ, ce_n, op});
    apb(1, IDX_IDLE_REQUEST, 8'h02);
    #1;
    chk(flash_req_valid, !bad);
    chk({cpu_stall, cpu_idle}, 2'b10);
    if (!bad) chk(flash_req, {op, ldr, bk, op == ISP_OP_ERASE ? 16'h0 : a, d});
    n = 0;
    while (cpu_stall === 1'b1 && n < 40) begin
      @(posedge pclk);
      #1;
      n++;
    end
    if (n >= 40) mismatches++;
    chk(flash_req_valid, 0);
    if (bad) chk(n, 1);
    else if (op == ISP_OP_ERASE) begin
      foreach (ref_mem[j]) if (j[17:16] == k[17:16]) kq.push_back(j);
      foreach (kq[j]) ref_mem.delete(kq[j]);
    end else if (op == ISP_OP_PROGRAM) ref_mem[k] = d;
    else begin
      apb(0, IDX_PROGRAM_DATA_BUFFER, 8'h00);
      chk(rdat, {24'h0, exp_rd(k)});
    end
  endtask : flash_op

  initial begin
    #3_000_000;
    mismatches++;
    give_verdict();
  end

  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, IDX_ROM_BANK_CONTROL, 8'h00);
    chk(rdat, {24'h0, RBC_RESET});
    chk(p1_a16_oe, 8'h00);
    for (int i = 0; i < 8; i++) begin
      apb(1, IDX_ROM_BANK_CONTROL, 8'h08 | 8'(i));
      code_addr16 <= 1'($random(seed));
      @(posedge pclk);
      #1;
      chk(p1_a16_oe, 8'h01 << i);
      chk(p1_a16_o[i], code_addr16);
    end
    apb(1, IDX_CHIP_PROGRAM_CONTROL, 8'h20);
    apb(0, IDX_CHIP_PROGRAM_CONTROL, 8'h00);
    chk(rdat & 32'ha3, 32'h00);
    apb(1, IDX_CHIP_PROGRAM_CONTROL, 8'h02);
    apb(0, IDX_CHIP_PROGRAM_CONTROL, 8'h00);
    chk(rdat & 32'ha3, 32'h22);
    chk(fetch_from_loader, 1);
    hw_reboot_strap <= 1'b1;
    repeat (3) @(posedge pclk);
    apb(0, IDX_CHIP_PROGRAM_CONTROL, 8'h00);
    chk(rdat[7], 1);
    hw_reboot_strap <= 1'b0;
    apb(1, IDX_CHIP_PROGRAM_CONTROL, 8'h01);
    flash_op(ISP_OP_PROGRAM, 0, 1, 16'h0a01, 8'h3c, 0);
    flash_op(ISP_OP_READ, 0, 0, 16'h0a01, 8'h00, 0);
    flash_op(ISP_OP_READ, 0, 1, 16'h0a01, 8'h00, 0);
    flash_op(ISP_OP_PROGRAM, 0, 0, 16'h0a02, 8'h11, 1);
    flash_op(4'h7, 1, 0, 16'h0a02, 8'h11, 0);
    for (int i = 0; i < 30; i++) begin
      r = $random(seed);
      flash_op(i % 6 == 5 ? ISP_OP_ERASE : (r[0] ? ISP_OP_PROGRAM : ISP_OP_READ), r[1], r[2],
               {14'h0280, r[4:3]}, r[15:8], 0);
    end
    apb(1, IDX_CHIP_PROGRAM_CONTROL, 8'h00);
    apb(1, IDX_IDLE_REQUEST, 8'h02);
    #1;
    chk({cpu_idle, flash_req_valid}, 2'b10);
    @(posedge pclk);
    cpu_wake <= 1'b1;
    @(posedge pclk);
    cpu_wake <= 1'b0;
    @(posedge pclk);
    #1;
    chk(cpu_idle, 0);
    apb(0, 8'h10, 8'h00);
    chk(rerr, 1);
    chk(rdat, 32'h0);
    n0 = sr_cnt;
    apb(1, IDX_ROM_BANK_CONTROL, 8'h0c);
    apb(1, IDX_CHIP_PROGRAM_CONTROL, 8'h82);
    repeat (3) @(posedge pclk);
    chk(sr_cnt, n0 + 1);
    apb(0, IDX_ROM_BANK_CONTROL, 8'h00);
    chk(rdat, {24'h0, RBC_RESET});
    apb(1, IDX_CHIP_PROGRAM_CONTROL, CPC_SW_RESTART_VALUE);
    apb(1, IDX_IDLE_REQUEST, 8'h02);
    #1;
    chk(cpu_idle, 1);
    chk(sr_cnt, n0 + 1);
    @(posedge pclk);
    restart_timer_expired <= 1'b1;
    @(posedge pclk);
    restart_timer_expired <= 1'b0;
    repeat (4) @(posedge pclk);
    #1;
    chk(fetch_from_loader, 0);
    chk(sr_cnt, n0 + 2);
    apb(0, IDX_CHIP_PROGRAM_CONTROL, 8'h00);
    chk(rdat & 32'h23, 32'h00);
    give_verdict();
  end
endmodule : isp_flash_sequencer_test
